// ---- dv/fpbw_flash_block_bench.sv ----
`timescale 1ns/10ps
module fpbw_flash_block_bench;
    logic                 core_clk = 1'b0;
    logic                 sys_rst = 1'b1;
    logic                 clk_en = 1'b1;
    logic                 wr_req;
    fpbw_pkg::fpbw_wreq_t wr_info;
    logic                 busy, wr_done, page_valid, blk_valid;
    logic [10:0]          page_num;
    logic [2:0]           blk_idx;
    int                   miscompares = 0;
    int                   checks = 0;
    int                   cyc = 0;
    localparam logic [31:0] WDATA = 32'hA5C31E7F;
    fpbw_flash_block u_fpbw_flash_block (.core_clk(core_clk),
        .sys_rst(sys_rst), .clk_en(clk_en), .wr_req(wr_req),
        .wr_info(wr_info), .busy(busy), .wr_done(wr_done),
        .page_num(page_num), .page_valid(page_valid), .blk_idx(blk_idx),
        .blk_valid(blk_valid));
    fpbw_user u_fpbw_user (.core_clk(core_clk), .clk_en(clk_en), .busy(busy),
        .wr_req(wr_req), .wr_info(wr_info));
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    task automatic chk(input string n, input logic [31:0] e, s);
        checks++;
        if (e !== s) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [17:0] a, input logic [1:0] w, int lat);
        int         n;
        int         nb;
        logic [3:0] base;
        logic [3:0] ofs;
        logic [7:0] bb;
        logic [7:0] pb;
        u_fpbw_user.send(a, w);
        n = 1;
        while (wr_done !== 1'b1 && n < 300) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("latency", lat, n);
        chk("page_num", 32'(a[17:7]), 32'(page_num));
        chk("blk_idx", 32'(a[6:4]), 32'(blk_idx));
        chk("valid", 32'h3, 32'({page_valid, blk_valid}));
        // Lane l of the word lands at the aligned base plus l
        nb   = (w == 2'h0) ? 1 : ((w == 2'h1) ? 2 : 4);
        base = a[3:0] & ~4'(nb - 1);
        for (int l = 0; l < nb; l++) begin
            ofs = base + 4'(l);
            bb  = u_fpbw_flash_block.blk_buf_q[ofs];
            pb  = u_fpbw_flash_block.page_buf_q[{a[6:4], ofs}];
            chk("blk_buf", 32'(WDATA[8*l +: 8]), 32'(bb));
            chk("page_buf", 32'(WDATA[8*l +: 8]), 32'(pb));
        end
    endtask
    task automatic chk_erased(input logic [6:0] o);
        logic [7:0] pb;
        pb = u_fpbw_flash_block.page_buf_q[o];
        chk("erased", 32'hFF, 32'(pb));
    endtask
    task automatic t_fetch;
        wr(18'h002A0, 2'h2, 131);
        chk_erased(7'h7F);
    endtask
    task automatic t_widths;
        for (int w = 0; w < 4; w++) wr(18'(18'h002A1 + w), 2'(w), 2);
    endtask
    task automatic t_block;
        wr(18'h002F3, 2'h3, 3);
        wr(18'h002F3, 2'h1, 2);
    endtask
    task automatic t_new_page;
        wr(18'h3FF8F, 2'h0, 131);
        chk_erased(7'h70);
    endtask
    task automatic t_freeze;
        @(posedge core_clk);
        #1 clk_en = 1'b0;
        fork
            wr(18'h00010, 2'h2, 131);
            begin
                repeat (3) @(posedge core_clk);
                #1 chk("frozen busy", 32'h0, 32'(busy));
                clk_en = 1'b1;
            end
        join
    endtask
    task automatic end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 1000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        t_fetch();
        t_widths();
        t_block();
        t_new_page();
        t_freeze();
        end_sim();
    end
endmodule // fpbw_flash_block_bench

// ---- dv/fpbw_flash_block_props.sv ----
`timescale 1ns/10ps
module fpbw_flash_block_props (
    input wire logic                       core_clk,
    input wire logic                       sys_rst,
    input wire logic                       clk_en,
    input wire logic                       wr_req,
    input wire fpbw_pkg::fpbw_wreq_t       wr_info,
    input wire logic                       busy,
    input wire logic                       wr_done,
    input wire logic [fpbw_pkg::PAGE_NUM_W-1:0] page_num,
    input wire logic                       page_valid,
    input wire logic [fpbw_pkg::BLK_IDX_W-1:0]  blk_idx,
    input wire logic                       blk_valid
);
    wire logic tk = clk_en && !busy && wr_req;
    wire logic ph = page_valid && page_num == wr_info.addr[17:7];
    wire logic bh = blk_valid && blk_idx == wr_info.addr[6:4];
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_busy; tk |=> busy; endproperty
    a_busy: assert property (p_busy) else $error("busy low");
    property p_hit; tk && ph && bh |=> busy ##1 wr_done && !busy; endproperty
    a_hit: assert property (p_hit) else $error("hit late");
    property p_blk; tk && ph && !bh |=> busy ##1 busy ##1 wr_done
        && blk_idx == $past(wr_info.addr[6:4], 3); endproperty
    a_blk: assert property (p_blk) else $error("block miss");
    property p_page; tk && !ph |-> ##131 wr_done; endproperty
    a_page: assert property (p_page) else $error("page miss");
    property p_pnum; tk && !ph |-> ##129 page_valid && !blk_valid
        && page_num == $past(wr_info.addr[17:7], 129); endproperty
    a_pnum: assert property (p_pnum) else $error("page num");
    property p_sync; wr_done |-> blk_valid && page_valid; endproperty
    a_sync: assert property (p_sync) else $error("not held");
    property p_pulse; wr_done |=> !wr_done; endproperty
    a_pulse: assert property (p_pulse) else $error("long done");
    property p_idle; !busy && !wr_req |=> !busy && !wr_done; endproperty
    a_idle: assert property (p_idle) else $error("no request");
endmodule // fpbw_flash_block_props
bind fpbw_flash_block fpbw_flash_block_props u_props (.core_clk(core_clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .wr_req(wr_req), .wr_info(wr_info),
    .busy(busy), .wr_done(wr_done), .page_num(page_num),
    .page_valid(page_valid), .blk_idx(blk_idx), .blk_valid(blk_valid));

// ---- dv/fpbw_user.sv ----
`timescale 1ns/10ps
module fpbw_user (
    input  wire logic           core_clk,
    input  wire logic           clk_en,
    input  wire logic           busy,
    output logic                wr_req,
    output fpbw_pkg::fpbw_wreq_t wr_info
);
    initial begin
        wr_req = 1'b0;
        wr_info = '0;
    end
    // Held until taken at an edge with busy low and clk_en high
    task automatic send(input logic [17:0] a, input logic [1:0] w);
        logic [31:0] d;
        logic        taken;
        d = 32'hA5C31E7F;
        if (w == 2'h0) d[31:8] = 24'h000000;
        if (w == 2'h1) d[31:16] = 16'h0000;
        wr_info = '{a, w, d};
        wr_req = 1'b1;
        // Take judged on settled levels ahead of the edge
        do begin
            @(negedge core_clk);
            taken = (busy === 1'b0) && (clk_en === 1'b1);
            @(posedge core_clk);
        end while (!taken);
        #1;
        wr_req = 1'b0;
        wr_info = ~wr_info;
    endtask
endmodule // fpbw_user

// ---- rtl/fpbw_flash_block.sv ----
`timescale 1ns/10ps

// Notes on behaviour
// - Accesses are one, two or four bytes wide only.
// - Writing an unbuffered page first fetches the whole page from the array.
// - Addressed block goes into block buffer; addressed bytes replaced by write data.
// - Updated block buffer is copied into its page buffer block.
// - Writes to the held block update both buffers without reloading.
// - Write to another block loads it from page buffer first.
// - Width select 00 one byte, 01 two bytes, 10/11 four bytes.
// - Addresses resolve to single 8-bit bytes.
// - Two-byte ignores address bit 0; four-byte ignores bits 1:0.
module fpbw_flash_block (
    input  wire logic                       core_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       clk_en,
    input  wire logic                       wr_req,
    input  wire fpbw_pkg::fpbw_wreq_t       wr_info,
    output logic                            busy,
    output logic                            wr_done,
    output logic [fpbw_pkg::PAGE_NUM_W-1:0] page_num,
    output logic                            page_valid,
    output logic [fpbw_pkg::BLK_IDX_W-1:0]  blk_idx,
    output logic                            blk_valid
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [fpbw_pkg::BYTE_W-1:0] array_mem  [fpbw_pkg::PAGES]
                                            [fpbw_pkg::PAGE_BYTES];
    logic [fpbw_pkg::BYTE_W-1:0] page_buf_q [fpbw_pkg::PAGE_BYTES];
    logic [fpbw_pkg::BYTE_W-1:0] blk_buf_q  [fpbw_pkg::BLK_BYTES];
    // Next-value copies of both buffers
    logic [fpbw_pkg::BYTE_W-1:0] page_buf_d [fpbw_pkg::PAGE_BYTES];
    logic [fpbw_pkg::BYTE_W-1:0] blk_buf_d  [fpbw_pkg::BLK_BYTES];

    fpbw_pkg::fpbw_state_t              state_q, state_d;
    fpbw_pkg::fpbw_wreq_t               req_q, req_d;
    logic [fpbw_pkg::PAGE_NUM_W-1:0]    page_q, page_d;
    logic                               pval_q, pval_d;
    logic [fpbw_pkg::BLK_IDX_W-1:0]     blk_q, blk_d;
    logic                               bval_q, bval_d;
    logic [fpbw_pkg::PAGE_OFS_W-1:0]    fcnt_q, fcnt_d;
    logic                               done_q, done_d;

    logic [fpbw_pkg::PAGE_NUM_W-1:0]    req_page;
    logic [fpbw_pkg::BLK_IDX_W-1:0]     req_blk;
    logic [fpbw_pkg::BLK_OFS_W-1:0]     req_ofs;
    logic [1:0]                         align_mask;
    logic [3:0]                         lane_en;
    logic [fpbw_pkg::BLK_OFS_W-1:0]     lane_ofs  [fpbw_pkg::LANES];
    logic [fpbw_pkg::BYTE_W-1:0]        lane_byte [fpbw_pkg::LANES];

    // ************************************************************
    // Address split and width decode
    // ************************************************************
    always_comb begin
        unique case (req_q.access_width_sel)
            fpbw_pkg::WSEL_1B: begin
                align_mask = fpbw_pkg::ALIGN_1B;
                lane_en    = fpbw_pkg::MASK_1B;
            end
            fpbw_pkg::WSEL_2B: begin
                align_mask = fpbw_pkg::ALIGN_2B;
                lane_en    = fpbw_pkg::MASK_2B;
            end
            // Codes 10 and 11 both take four bytes
            default: begin
                align_mask = fpbw_pkg::ALIGN_4B;
                lane_en    = fpbw_pkg::MASK_4B;
            end
        endcase
        req_page = req_q.addr[fpbw_pkg::ADDR_W-1:fpbw_pkg::PAGE_OFS_W];
        req_blk  = req_q.addr[fpbw_pkg::PAGE_OFS_W-1:fpbw_pkg::BLK_OFS_W];
        // Byte resolution, low bits dropped per width
        req_ofs  = {req_q.addr[fpbw_pkg::BLK_OFS_W-1:2],
                    req_q.addr[1:0] & align_mask};
    end

    // ************************************************************
    // Control
    // ************************************************************
    always_comb begin
        state_d = state_q;
        req_d   = req_q;
        page_d  = page_q;
        pval_d  = pval_q;
        blk_d   = blk_q;
        bval_d  = bval_q;
        fcnt_d  = fcnt_q;
        done_d  = 1'b0;
        case (state_q)
            fpbw_pkg::ST_IDLE: begin
                // Only taken while idle; requests while busy are dropped
                if (wr_req) begin
                    req_d   = wr_info;
                    state_d = fpbw_pkg::ST_MERGE;
                    if (!pval_q || (page_q != wr_info.addr[
                        fpbw_pkg::ADDR_W-1:fpbw_pkg::PAGE_OFS_W])) begin
                        state_d = fpbw_pkg::ST_FETCH;
                        fcnt_d  = '0;
                    end else if (!bval_q || (blk_q != wr_info.addr[
                        fpbw_pkg::PAGE_OFS_W-1:fpbw_pkg::BLK_OFS_W])) begin
                        state_d = fpbw_pkg::ST_LOAD;
                    end
                end
            end
            fpbw_pkg::ST_FETCH: begin
                fcnt_d = fcnt_q + 1'b1;
                if (fcnt_q == fpbw_pkg::PAGE_OFS_W'(fpbw_pkg::PAGE_BYTES - 1))
                begin
                    page_d  = req_page;
                    pval_d  = 1'b1;
                    // Old block copy belonged to the old page
                    bval_d  = 1'b0;
                    state_d = fpbw_pkg::ST_LOAD;
                end
            end
            fpbw_pkg::ST_LOAD: begin
                blk_d   = req_blk;
                bval_d  = 1'b1;
                state_d = fpbw_pkg::ST_MERGE;
            end
            fpbw_pkg::ST_MERGE: begin
                // Both buffers take the bytes at this edge
                done_d  = 1'b1;
                state_d = fpbw_pkg::ST_IDLE;
            end
            default: state_d = fpbw_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= fpbw_pkg::ST_IDLE;
            req_q   <= '0;
            page_q  <= '0;
            pval_q  <= 1'b0;
            blk_q   <= '0;
            bval_q  <= 1'b0;
            fcnt_q  <= '0;
            done_q  <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            req_q   <= req_d;
            page_q  <= page_d;
            pval_q  <= pval_d;
            blk_q   <= blk_d;
            bval_q  <= bval_d;
            fcnt_q  <= fcnt_d;
            done_q  <= done_d;
        end
    end

    // ************************************************************
    // Lane mapping, one generate branch per byte lane
    // ************************************************************
    for (genvar l = 0; l < fpbw_pkg::LANES; l++) begin : g_lane
        // Lane l lands at aligned base plus l
        assign lane_ofs[l]  = req_ofs + fpbw_pkg::BLK_OFS_W'(l);
        assign lane_byte[l] = req_q.write_data_bus[l*fpbw_pkg::BYTE_W +:
                                                   fpbw_pkg::BYTE_W];
    end

    // ************************************************************
    // Buffer datapath
    // ************************************************************
    always_comb begin
        page_buf_d = page_buf_q;
        blk_buf_d  = blk_buf_q;
        if (state_q == fpbw_pkg::ST_FETCH) begin
            page_buf_d[fcnt_q] = array_mem[req_page][fcnt_q];
        end

        if (state_q == fpbw_pkg::ST_LOAD) begin
            for (int i = 0; i < fpbw_pkg::BLK_BYTES; i++) begin
                blk_buf_d[i] = page_buf_q[{req_blk,
                                fpbw_pkg::BLK_OFS_W'(i)}];
            end
        end

        if (state_q == fpbw_pkg::ST_MERGE) begin
            for (int l = 0; l < fpbw_pkg::LANES; l++) begin
                if (lane_en[l]) begin
                    blk_buf_d[lane_ofs[l]] = lane_byte[l];
                    // Same bytes into the page copy keeps both in step
                    page_buf_d[{req_blk, lane_ofs[l]}] =
                        lane_byte[l];
                end
            end
        end
    end

    // Buffers are not reset; only fetched or written bytes matter
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            page_buf_q <= page_buf_d;
            blk_buf_q  <= blk_buf_d;
        end
    end

    // Array is read only on this path; programming lives elsewhere
    initial begin
        for (int p = 0; p < fpbw_pkg::PAGES; p++) begin
            for (int b = 0; b < fpbw_pkg::PAGE_BYTES; b++) begin
                array_mem[p][b] = '1;
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Busy decoded straight from the state register
    assign busy       = (state_q != fpbw_pkg::ST_IDLE);
    assign wr_done    = done_q;
    assign page_num   = page_q;
    assign page_valid = pval_q;
    assign blk_idx    = blk_q;
    assign blk_valid  = bval_q;

endmodule // fpbw_flash_block

// ---- rtl/fpbw_pkg.sv ----
package fpbw_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int ADDR_W       = 18;
    localparam int DATA_W       = 32;
    localparam int BYTE_W       = 8;
    localparam int LANES        = 4;
    localparam int BLK_BYTES    = 16;
    localparam int BLK_OFS_W    = 4;
    localparam int PAGE_BLKS    = 8;
    localparam int BLK_IDX_W    = 3;
    localparam int PAGE_BYTES   = 128;
    localparam int PAGE_OFS_W   = 7;
    localparam int PAGE_NUM_W   = 11;
    localparam int PAGES        = 2048;

    // ************************************************************
    // Width select encodings
    // ************************************************************
    localparam logic [1:0] WSEL_1B  = 2'h0;
    localparam logic [1:0] WSEL_2B  = 2'h1;

    localparam logic [1:0] ALIGN_1B = 2'h3;
    localparam logic [1:0] ALIGN_2B = 2'h2;
    localparam logic [1:0] ALIGN_4B = 2'h0;

    localparam logic [3:0] MASK_1B  = 4'h1;
    localparam logic [3:0] MASK_2B  = 4'h3;
    localparam logic [3:0] MASK_4B  = 4'hF;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [1:0]        access_width_sel;
        logic [DATA_W-1:0] write_data_bus;
    } fpbw_wreq_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_LOAD,
        ST_MERGE
    } fpbw_state_t;

endpackage
